// ---- src/usm_pkg.sv ----
/*
  Shared constants and carrier types for the serial channel with
  multi-processor address filtering.
  Assumes a single core clock; register indices are fixed by this package.
*/
package usm_pkg;
  // ****************************************************************
  // register locations and field positions
  // ****************************************************************
  localparam logic [1:0] REG_DATA   = 2'h0;
  localparam logic [1:0] REG_STAT_A = 2'h1;
  localparam logic [1:0] REG_CTRL_B = 2'h2;
  localparam logic [1:0] REG_CTRL_C = 2'h3;

  localparam int A_RXC  = 7;
  localparam int A_TXC  = 6;
  localparam int A_UDRE = 5;
  localparam int A_FE   = 4;
  localparam int A_DOR  = 3;
  localparam int A_UPE  = 2;
  localparam int A_U2X  = 1;
  localparam int A_MPCM = 0;

  localparam int B_RXCIE = 7;
  localparam int B_TXCIE = 6;
  localparam int B_UDRIE = 5;
  localparam int B_RXEN  = 4;
  localparam int B_TXEN  = 3;
  localparam int B_UCSZ2 = 2;
  localparam int B_RXB8  = 1;
  localparam int B_TXB8  = 0;

  localparam int C_MODE_LO = 6;
  localparam int C_PAR_LO  = 4;
  localparam int C_STOP    = 3;
  localparam int C_SIZE_LO = 1;

  // ****************************************************************
  // reset values, encodings, timing
  // ****************************************************************
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_C_RESET = 8'h06;
  localparam logic [1:0] MODE_ASYNC   = 2'h0;
  localparam logic [1:0] MODE_SYNC    = 2'h1;
  localparam logic [1:0] MODE_SPI     = 2'h3;
  localparam logic [4:0] SPB_NORMAL   = 5'h10;
  localparam logic [4:0] SPB_DOUBLE   = 5'h08;
  localparam int         FRAME_W      = 13;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       frame_err;
    logic       parity_err;
  } usm_rx_word_t;
endpackage

// ---- src/usm_two_buf.sv ----
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes the drain side may stall; the head entry is always held in slot 0
  so that the output data come straight from a flip-flop.
*/
`timescale 1ns/1ps
module usm_two_buf #(
  parameter int WIDTH = 11
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] slot1;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= 2'h0;
    end else if (flush_in) begin
      count <= 2'h0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_data_out <= '0;
      slot1        <= '0;
    end else begin
      if (pop) begin
        out_data_out <= (count == 2'h2) ? slot1 : in_data_in;
      end else if (push && count == 2'h0) begin
        out_data_out <= in_data_in;
      end
      if (push && (count - {1'b0, pop}) == 2'h1) begin
        slot1 <= in_data_in;
      end
    end
  end
endmodule

// ---- src/usm_channel.sv ----
/*
  Serial transceiver channel: data port, status/control registers,
  two-entry receive buffer, transmit buffer and shifter, address filter.
  Assumes a CPU-side register port with one-cycle read latency and a
  global interrupt enable supplied by the CPU core.
*/
`timescale 1ns/1ps
// Behaviour
// - with filter bit set, data frames are dropped; address frames and transmit unaffected.
// - data port write fills transmit buffer; read returns receive buffer.
// - unused upper bits ignored on transmit and read back as zero.
// - data port write while buffer not empty is discarded.
// - enabled transmitter moves buffered data into idle shifter, then shifts it out.
// - receive buffer is two-entry, advancing on each data port read.
// - receive-complete flag is one exactly while receive buffer holds data.
// - transmit-complete sets when frame out and buffer empty; clears on service or one.
// - buffer-empty flag is one when buffer can accept data, and after reset.
// - frame-error reports head character's first stop bit sampled zero.
// - overrun sets when buffer full, character waiting and new start bit seen.
// - parity-error reports head character's parity mismatch while checking enabled.
// - double-speed bit halves samples per bit, asynchronous mode only.
// - each interrupt requested only when its enable, global enable and flag are set.
// - enabled receiver owns input pin; disabling flushes buffer and error flags.
// - transmitter disable waits until shifter and buffer are empty, then releases pin.
// - mode field selects async, sync, reserved, master SPI; resets to zero.
// - size code 000..011 gives five to eight bits, 111 gives nine.
// - frame-type bit one marks an address frame, zero a data frame.
// - parity field: disabled, reserved, even, odd; governs generation and checking.
module usm_channel
  import usm_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = 16'h0004
) (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       global_irq_enable_in,
  input  wire logic       tx_complete_irq_ack_in,
  output logic            rx_complete_irq_out,
  output logic            tx_complete_irq_out,
  output logic            buffer_empty_irq_out,
  input  wire logic       serial_in_pin_in,
  output logic            serial_in_owned_out,
  output logic            serial_out_pin_out,
  output logic            serial_out_oe_n_out,
  output logic      [1:0] mode_select_out
);
  import usm_pkg::*;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS  = 4'b0100,
    RX_HOLD  = 4'b1000
  } usm_rx_state_t;

  // ****************************************************************
  // register state
  // ****************************************************************
  logic        multiproc_filter_bit;
  logic        double_speed_bit;
  logic        tx_complete_flag;
  logic        overrun_flag;
  logic [7:0]  serial_control_b;
  logic [7:0]  serial_control_c;
  logic        tx_full;
  logic [8:0]  tx_buf;
  logic        tx_active;

  logic        wr_data;
  logic        rd_data;
  logic        wr_a;
  logic        receiver_enable_bit;
  logic        transmitter_enable_bit;
  logic        tx_ninth_bit;
  logic [2:0]  char_size_field;
  logic [1:0]  parity_mode_field;
  logic [3:0]  nbits;
  logic        par_on;
  logic [4:0]  spb;

  function automatic logic [3:0] size_bits(input logic [2:0] code);
    case (code)
      3'h0:    size_bits = 4'h5;
      3'h1:    size_bits = 4'h6;
      3'h2:    size_bits = 4'h7;
      3'h7:    size_bits = 4'h9;
      default: size_bits = 4'h8; // reserved codes behave as eight bits
    endcase
  endfunction

  assign wr_data                = reg_wr_in && reg_addr_in == REG_DATA;
  assign rd_data                = reg_rd_in && reg_addr_in == REG_DATA;
  assign wr_a                   = reg_wr_in && reg_addr_in == REG_STAT_A;
  assign receiver_enable_bit    = serial_control_b[B_RXEN];
  assign transmitter_enable_bit = serial_control_b[B_TXEN];
  assign tx_ninth_bit           = serial_control_b[B_TXB8];
  assign char_size_field        = {serial_control_b[B_UCSZ2], serial_control_c[C_SIZE_LO +: 2]};
  assign parity_mode_field      = serial_control_c[C_PAR_LO +: 2];
  assign mode_select_out        = serial_control_c[C_MODE_LO +: 2];
  assign nbits                  = size_bits(char_size_field);
  assign par_on                 = parity_mode_field[1];
  assign spb = (double_speed_bit && mode_select_out == MODE_ASYNC) ? SPB_DOUBLE : SPB_NORMAL;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_control_b <= CTRL_B_RESET;
      serial_control_c <= CTRL_C_RESET;
    end else if (reg_wr_in && reg_addr_in == REG_CTRL_B) begin
      // received ninth bit is read-only
      serial_control_b <= {reg_wdata_in[7:2], serial_control_b[B_RXB8], reg_wdata_in[B_TXB8]};
    end else if (reg_wr_in && reg_addr_in == REG_CTRL_C) begin
      serial_control_c <= reg_wdata_in;
    end
  end

  // error bit positions are ignored on write, so a stray one cannot corrupt them
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      multiproc_filter_bit <= 1'b0;
      double_speed_bit     <= 1'b0;
    end else if (wr_a) begin
      multiproc_filter_bit <= reg_wdata_in[A_MPCM];
      double_speed_bit     <= reg_wdata_in[A_U2X];
    end
  end

  // ****************************************************************
  // sample tick prescaler
  // ****************************************************************
  logic [15:0] pre_cnt;
  logic        tick;

  assign tick = (pre_cnt == BAUD_DIV - 16'h0001);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_cnt <= 16'h0000;
    end else if (tick) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // ****************************************************************
  // input pin synchroniser
  // ****************************************************************
  logic [2:0] rx_sync;
  logic       line;
  logic       line_prev;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_sync   <= 3'h7;
      line      <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      rx_sync   <= {rx_sync[1:0], serial_in_pin_in};
      line_prev <= line;
      if (rx_sync[1] == rx_sync[2]) begin
        line <= rx_sync[2];
      end
    end
  end

  // ****************************************************************
  // receiver
  // ****************************************************************
  usm_rx_state_t rx_state;
  logic [4:0]    rx_cnt;
  logic [3:0]    rx_bit;
  logic [10:0]   rx_shift;
  usm_rx_word_t  rx_word;
  usm_rx_word_t  head;
  logic          rx_done;
  logic          frame_type;
  logic          par_calc;
  logic          buf_ready;
  logic          buf_valid;
  logic [8:0]    rx_mask;

  assign serial_in_owned_out = receiver_enable_bit;
  assign rx_done = rx_state == RX_BITS && tick && rx_cnt == spb - 5'h01
                   && rx_bit == nbits + {3'h0, par_on};
  assign rx_mask = 9'h1ff >> (4'h9 - nbits);

  always_comb begin
    rx_word            = '0;
    {rx_word.ninth, rx_word.data} = rx_shift[8:0] & rx_mask;
    par_calc           = ^(rx_shift[8:0] & rx_mask) ^ parity_mode_field[0];
    if (nbits == 4'h9) begin
      rx_word.ninth = rx_shift[8];
      rx_word.data  = rx_shift[7:0];
      par_calc      = ^rx_shift[8:0] ^ parity_mode_field[0];
    end
    // the bit at index nbits is parity when enabled, else the first stop bit
    if (par_on) begin
      rx_word.parity_err = par_calc ^ rx_shift[nbits];
      rx_word.frame_err  = ~line;
    end else begin
      rx_word.frame_err  = ~line;
    end
    // ninth bit for 9-bit frames, first stop bit otherwise
    frame_type = (nbits == 4'h9) ? rx_shift[8] : line;
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 5'h00;
      rx_bit   <= 4'h0;
      rx_shift <= 11'h000;
    end else if (!receiver_enable_bit) begin
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_cnt <= 5'h00;
          rx_bit <= 4'h0;
          // start is a falling edge, so a low frame-type stop bit cannot restart the receiver
          if (!line && line_prev) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_cnt <= rx_cnt + 5'h01;
            if (rx_cnt == (spb >> 1) - 5'h01) begin
              rx_cnt   <= 5'h00;
              // a start bit gone high by mid-bit is treated as noise
              rx_state <= line ? RX_IDLE : RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_cnt <= rx_cnt + 5'h01;
            if (rx_cnt == spb - 5'h01) begin
              rx_cnt           <= 5'h00;
              rx_bit           <= rx_bit + 4'h1;
              rx_shift[rx_bit] <= line;
              if (rx_done) begin
                rx_state <= (multiproc_filter_bit && !frame_type) ? RX_IDLE : RX_HOLD;
              end
            end
          end
        end
        RX_HOLD: begin
          if (buf_ready) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // the completed word is latched so the shifter can hold it while the buffer is full
  usm_rx_word_t rx_pend;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_pend <= '0;
    end else if (rx_done) begin
      rx_pend <= rx_word;
    end
  end

  usm_two_buf #(
    .WIDTH($bits(usm_rx_word_t))
  ) u_rx_buf (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_in),
    .flush_in     (!receiver_enable_bit),
    .in_valid_in  (rx_state == RX_HOLD),
    .in_ready_out (buf_ready),
    .in_data_in   (rx_pend),
    .out_valid_out(buf_valid),
    .out_ready_in (rd_data),
    .out_data_out (head)
  );

  // set wins over the clearing read
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      overrun_flag <= 1'b0;
    end else if (!receiver_enable_bit) begin
      overrun_flag <= 1'b0;
    end else if (rx_state == RX_HOLD && !buf_ready && !line && line_prev) begin
      overrun_flag <= 1'b1;
    end else if (rd_data) begin
      overrun_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  logic [FRAME_W-1:0] tx_shift;
  logic [3:0]         tx_left;
  logic [4:0]         tx_cnt;
  logic               tx_busy;
  logic               tx_load;
  logic               tx_end;
  logic [8:0]         tx_data;
  logic [FRAME_W-1:0] tx_frame;
  logic [3:0]         tx_len;

  assign tx_load = tx_active && tx_full && !tx_busy;
  assign tx_end  = tx_busy && tick && tx_cnt == spb - 5'h01 && tx_left == 4'h1;
  assign tx_data = tx_buf & rx_mask;

  always_comb begin
    tx_frame         = {FRAME_W{1'b1}};
    tx_frame[0]      = 1'b0;
    // unused data positions stay high, so short characters are followed by stop bits
    tx_frame[9:1]    = tx_data | ~rx_mask;
    if (par_on) begin
      tx_frame[nbits + 4'h1] = ^tx_data ^ parity_mode_field[0];
    end
    tx_len = 4'h2 + nbits + {3'h0, par_on} + {3'h0, serial_control_c[C_STOP]};
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_full <= 1'b0;
      tx_buf  <= 9'h000;
    end else if (wr_data && !tx_full) begin
      // a write to a full buffer is dropped
      tx_full <= 1'b1;
      tx_buf  <= {tx_ninth_bit, reg_wdata_in};
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_busy  <= 1'b0;
      tx_shift <= {FRAME_W{1'b1}};
      tx_left  <= 4'h0;
      tx_cnt   <= 5'h00;
    end else if (tx_load) begin
      tx_busy  <= 1'b1;
      tx_shift <= tx_frame;
      tx_left  <= tx_len;
      tx_cnt   <= 5'h00;
    end else if (tx_busy && tick) begin
      tx_cnt <= tx_cnt + 5'h01;
      if (tx_cnt == spb - 5'h01) begin
        tx_cnt   <= 5'h00;
        tx_shift <= {1'b1, tx_shift[FRAME_W-1:1]};
        tx_left  <= tx_left - 4'h1;
        tx_busy  <= !tx_end;
      end
    end
  end

  // disable takes hold only once nothing is pending
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_active <= 1'b0;
    end else begin
      tx_active <= transmitter_enable_bit || (tx_active && (tx_busy || tx_full));
    end
  end

  assign serial_out_pin_out  = tx_busy ? tx_shift[0] : 1'b1;
  assign serial_out_oe_n_out = !tx_active;

  // set wins over clear by service or by writing one
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_complete_flag <= 1'b0;
    end else if (tx_end && !tx_full) begin
      tx_complete_flag <= 1'b1;
    end else if (tx_complete_irq_ack_in || (wr_a && reg_wdata_in[A_TXC])) begin
      tx_complete_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // read port and interrupt requests
  // ****************************************************************
  logic [7:0] stat_a;

  always_comb begin
    stat_a         = 8'h00;
    stat_a[A_RXC]  = buf_valid;
    stat_a[A_TXC]  = tx_complete_flag;
    stat_a[A_UDRE] = !tx_full;
    stat_a[A_FE]   = buf_valid && head.frame_err;
    stat_a[A_DOR]  = overrun_flag;
    stat_a[A_UPE]  = buf_valid && head.parity_err;
    stat_a[A_U2X]  = double_speed_bit;
    stat_a[A_MPCM] = multiproc_filter_bit;
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_DATA:   reg_rdata_out <= buf_valid ? head.data : 8'h00;
        REG_STAT_A: reg_rdata_out <= stat_a;
        REG_CTRL_B: reg_rdata_out <= {serial_control_b[7:2], buf_valid && head.ninth,
                                      serial_control_b[B_TXB8]};
        default:    reg_rdata_out <= serial_control_c;
      endcase
    end
  end

  assign rx_complete_irq_out  = global_irq_enable_in && serial_control_b[B_RXCIE] && stat_a[A_RXC];
  assign tx_complete_irq_out  = global_irq_enable_in && serial_control_b[B_TXCIE] && tx_complete_flag;
  assign buffer_empty_irq_out = global_irq_enable_in && serial_control_b[B_UDRIE] && stat_a[A_UDRE];
endmodule

// ---- sim/usm_channel_properties.sv ----
/*
  Port checker for the serial channel, bound to every channel instance.
  Assumes at least eight core cycles per serial bit.
*/
`timescale 1ns/1ps
module usm_channel_props
  import usm_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = 16'h0004
) (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       global_irq_enable_in,
  input wire logic       tx_complete_irq_ack_in,
  input wire logic       rx_complete_irq_out,
  input wire logic       tx_complete_irq_out,
  input wire logic       buffer_empty_irq_out,
  input wire logic       serial_in_pin_in,
  input wire logic       serial_in_owned_out,
  input wire logic       serial_out_pin_out,
  input wire logic       serial_out_oe_n_out,
  input wire logic [1:0] mode_select_out
);
  logic wr_b;
  assign wr_b = reg_wr_in && reg_addr_in == REG_CTRL_B;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_irq_gate;
    (rx_complete_irq_out || tx_complete_irq_out || buffer_empty_irq_out) |-> global_irq_enable_in;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  property p_mode;
    reg_wr_in && reg_addr_in == REG_CTRL_C |=> mode_select_out == $past(reg_wdata_in[7:6]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode field not taken");
  property p_owned;
    wr_b |=> serial_in_owned_out == $past(reg_wdata_in[B_RXEN]);
  endproperty
  a_owned: assert property (p_owned) else $error("input pin owner wrong");
  property p_tx_on;
    wr_b && reg_wdata_in[B_TXEN] |-> ##2 !serial_out_oe_n_out;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("enabled transmitter not driving");
  property p_idle;
    serial_out_oe_n_out |-> serial_out_pin_out;
  endproperty
  a_idle: assert property (p_idle) else $error("released pin not idle");
  property p_drive;
    $fell(serial_out_pin_out) |-> !serial_out_oe_n_out;
  endproperty
  a_drive: assert property (p_drive) else $error("bit sent while released");
  // shortest bit is eight ticks of one cycle each
  property p_bit_len;
    $fell(serial_out_pin_out) |=> !serial_out_pin_out [*7];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low bit too short");
  property p_txc_ack;
    tx_complete_irq_ack_in |=> !tx_complete_irq_out;
  endproperty
  a_txc_ack: assert property (p_txc_ack) else $error("serviced flag kept");
  property p_rd_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind usm_channel usm_channel_props #(.BAUD_DIV(BAUD_DIV)) u_props (.*);

// ---- sim/usm_serial_node.sv ----
/*
  Behavioural serial node on the far side of the line.
  Assumes nine-bit frames, one stop bit, no parity, SPB core cycles per bit.
*/
`timescale 1ns/1ps
module usm_serial_node #(
  parameter int SPB = 16
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [8:0] got_q[$];
  logic [8:0] acc;
  initial line_out = 1'b1;
  // ninth bit one marks an address frame, zero a data frame
  task automatic send(input logic [8:0] w);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (SPB) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      line_out <= w[i];
      repeat (SPB) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (SPB) @(posedge clk_in);
  endtask
  // sample mid-bit; stop bit only waited out
  always begin
    @(negedge line_in);
    repeat (SPB / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (SPB) @(posedge clk_in);
      acc = {line_in, acc[8:1]};
    end
    got_q.push_back(acc);
    repeat (SPB) @(posedge clk_in);
  end
endmodule

// ---- sim/usm_channel_tb_top.sv ----
/*
  Self-checking bench for the serial channel.
  Assumes one sample tick per core cycle, so a bit lasts 16 cycles.
*/
`timescale 1ns/1ps
module usm_channel_tb_top;
  import usm_pkg::*;
  logic       core_clk, rst, wr, rd, gie, ack, sin, owned, sout, oe_n, line;
  logic       rx_irq, tx_irq, be_irq;
  logic [1:0] addr, mode;
  logic [7:0] wd, rdata;
  logic [8:0] q[$];
  int         fails, check_count;
  assign line = oe_n ? 1'b1 : sout;
  usm_channel #(.BAUD_DIV(16'h0001)) uut (
    .core_clk_in(core_clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata),
    .global_irq_enable_in(gie), .tx_complete_irq_ack_in(ack),
    .rx_complete_irq_out(rx_irq), .tx_complete_irq_out(tx_irq),
    .buffer_empty_irq_out(be_irq), .serial_in_pin_in(sin),
    .serial_in_owned_out(owned), .serial_out_pin_out(sout),
    .serial_out_oe_n_out(oe_n), .mode_select_out(mode));
  usm_serial_node #(.SPB(16)) node (.clk_in(core_clk), .line_in(line), .line_out(sin));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [1:0] a, input logic [8:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(n, e, {1'b0, rdata});
  endtask
  function automatic logic [8:0] stat(input logic rxc, txc, dor, mpcm);
    return {1'b0, rxc, txc, 1'b1, 1'b0, dor, 2'b00, mpcm};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    {rst, wr, rd, gie, ack, addr, wd} = {1'b1, 4'h2, 2'h0, 8'h00};
    void'($urandom(32'h2a24e5ff));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rchk("ctrl_c", REG_CTRL_C, 9'h006);
    rchk("ctrl_b", REG_CTRL_B, 9'h000);
    rchk("stat_rst", REG_STAT_A, stat(0, 0, 0, 0));
    wr_reg(REG_CTRL_B, 8'h1c);
    wr_reg(REG_STAT_A, 8'h01);
    node.send({1'b0, 8'($urandom)});
    repeat (40) @(posedge core_clk);
    rchk("filtered", REG_STAT_A, stat(0, 0, 0, 1));
    q.push_back({1'b1, 8'($urandom)});
    node.send(q[0]);
    repeat (40) @(posedge core_clk);
    rchk("addr_stat", REG_STAT_A, stat(1, 0, 0, 1));
    rchk("ninth", REG_CTRL_B, 9'h01e);
    rchk("addr", REG_DATA, {1'b0, q[0][7:0]});
    wr_reg(REG_STAT_A, 8'h00);
    q.delete();
    for (int i = 0; i < 4; i++) begin
      q.push_back({1'b0, 8'($urandom)});
      node.send(q[i]);
    end
    repeat (40) @(posedge core_clk);
    rchk("overrun", REG_STAT_A, stat(1, 0, 1, 0));
    for (int i = 0; i < 3; i++) rchk("fifo", REG_DATA, q[i]);
    rchk("drained", REG_STAT_A, stat(0, 0, 0, 0));
    wr_reg(REG_CTRL_B, 8'h1d);
    q.delete();
    for (int i = 0; i < 3; i++) begin
      q.push_back({1'b1, 8'($urandom)});
      wr_reg(REG_DATA, q[i][7:0]);
    end
    repeat (450) @(posedge core_clk);
    chk("tx_count", 9'd2, 9'(node.got_q.size()));
    for (int i = 0; i < 2; i++) chk("tx_word", q[i], node.got_q[i]);
    rchk("tx_done", REG_STAT_A, stat(0, 1, 0, 0));
    wr_reg(REG_CTRL_B, 8'h7d);
    @(negedge core_clk);
    chk("irq_on", 9'h003, {6'h0, rx_irq, tx_irq, be_irq});
    @(posedge core_clk);
    gie <= 1'b0;
    @(negedge core_clk);
    chk("irq_off", 9'h000, {6'h0, rx_irq, tx_irq, be_irq});
    @(posedge core_clk);
    {gie, ack} <= 2'b11;
    @(posedge core_clk);
    ack <= 1'b0;
    rchk("tx_ack", REG_STAT_A, stat(0, 0, 0, 0));
    wr_reg(REG_CTRL_B, 8'h14);
    // the pin is let go one cycle after the disable is seen with nothing pending
    repeat (2) @(negedge core_clk);
    chk("released", 9'h003, {7'h0, oe_n, owned});
    for (int m = 0; m < 4; m++) begin
      wr_reg(REG_CTRL_C, {2'(m), 6'h06});
      @(negedge core_clk);
      chk("mode", 9'(m), {7'h0, mode});
    end
    // 8-bit characters: the node's ninth slot is the frame-type stop bit, then a real stop
    wr_reg(REG_CTRL_C, 8'h06);
    wr_reg(REG_CTRL_B, 8'h10);
    wr_reg(REG_STAT_A, 8'h01);
    q.delete();
    q.push_back({1'b0, 8'($urandom)});
    q.push_back({1'b1, 8'($urandom)});
    node.send(q[0]);
    node.send(q[1]);
    repeat (40) @(posedge core_clk);
    rchk("short_stat", REG_STAT_A, stat(1, 0, 0, 1));
    rchk("short_addr", REG_DATA, {1'b0, q[1][7:0]});
    wr_reg(REG_STAT_A, 8'h00);
    node.send(q[0]);
    repeat (40) @(posedge core_clk);
    rchk("frame_err", REG_STAT_A, 9'h0b0);
    rchk("short_data", REG_DATA, {1'b0, q[0][7:0]});
    final_report();
  end
endmodule
